// ===== hdl/multibyte_register_update.sv
`timescale 1ns/10ps
// Contract
// - Multi-byte fields stored least significant byte first.
// - Atomic lower bytes wait in staging buffer.
// - Atomic top byte applies whole field once.
// - Non-atomic bytes apply to logic immediately.
// - Bit zero is least significant bit.
// - Instance base equals block base plus index stride.
// - Lowercase n prefix means active low.
// - Byte, hword, word, dword are 8/16/32/64 bits.
module multibyte_register_update
   import regbank_pkg::*;
#(
   parameter int N_INST = NUM_INST
) (
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic WR_EN,
   input wire logic RD_EN,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [BYTE_W-1:0] WDATA,
   output logic [BYTE_W-1:0] RDATA,
   output logic RVALID,
   output logic [N_INST*FIELD_W-1:0] ATOMIC_FIELDS,
   output logic [N_INST*FIELD_W-1:0] PLAIN_FIELDS
);
   bus_req_t req;
   decode_t dec;
   logic [N_INST*FIELD_W-1:0] atomic_stage;
   logic [N_INST*FIELD_W-1:0] atomic_live;
   logic [N_INST*FIELD_W-1:0] plain_live;
   logic [BYTE_W-1:0] nxt_rdata;

   assign req = '{wr: WR_EN, rd: RD_EN, addr: ADDR, wdata: WDATA};

   always_comb begin
      logic [ADDR_W-1:0] rel;
      logic [ADDR_W-1:0] ofs;
      rel = '0;
      ofs = '0;
      dec = '0;
      for (int i = 0; i < N_INST; i++) begin
         rel = req.addr - (BLOCK_BASE + ADDR_W'(i) * INST_STRIDE);
         if (req.addr >= BLOCK_BASE + ADDR_W'(i) * INST_STRIDE && rel < INST_STRIDE) begin
            ofs = rel;
            dec.hit = 1'b1;
            dec.inst = 1'(i);
            dec.atomic = (ofs < PLAIN_OFS);
            dec.lane = ofs[1:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < N_INST; g++) begin : g_inst
         field_slot #(.ATOMIC(1'b1)) u_atomic (
            .clk(SYS_CLK),
            .rst_n(RSTN),
            .wr(req.wr && dec.hit && dec.atomic && dec.inst == 1'(g)),
            .lane(dec.lane),
            .wdata(req.wdata),
            .stage(atomic_stage[g*FIELD_W +: FIELD_W]),
            .live(atomic_live[g*FIELD_W +: FIELD_W])
         );
         field_slot #(.ATOMIC(1'b0)) u_plain (
            .clk(SYS_CLK),
            .rst_n(RSTN),
            .wr(req.wr && dec.hit && !dec.atomic && dec.inst == 1'(g)),
            .lane(dec.lane),
            .wdata(req.wdata),
            .stage(),
            .live(plain_live[g*FIELD_W +: FIELD_W])
         );
      end
   endgenerate

   always_comb begin
      nxt_rdata = BYTE_ZERO;
      if (dec.hit) begin
         if (dec.atomic) begin
            nxt_rdata = atomic_stage[dec.inst*FIELD_W + dec.lane*BYTE_W +: BYTE_W];
         end else begin
            nxt_rdata = plain_live[dec.inst*FIELD_W + dec.lane*BYTE_W +: BYTE_W];
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         RDATA <= BYTE_ZERO;
         RVALID <= 1'b0;
      end else begin
         RVALID <= req.rd;
         if (req.rd) begin
            RDATA <= nxt_rdata;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         ATOMIC_FIELDS <= '0;
         PLAIN_FIELDS <= '0;
      end else begin
         ATOMIC_FIELDS <= atomic_live;
         PLAIN_FIELDS <= plain_live;
      end
   end

   chk_read_latency: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      RD_EN |=> RVALID && RDATA == $past(nxt_rdata))
      else $error("Read data wrong or late.");
   chk_unmapped_zero: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (RD_EN && ADDR < BLOCK_BASE) |=> RDATA == BYTE_ZERO)
      else $error("Unmapped read not zero.");
   chk_inst1_base: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (WR_EN && ADDR == BLOCK_BASE + INST_STRIDE + PLAIN_OFS) |=> ##1
      PLAIN_FIELDS[FIELD_W +: BYTE_W] == $past(WDATA, 2))
      else $error("Instance one base misplaced.");
   chk_atomic_out: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (WR_EN && ADDR == BLOCK_BASE + ATOMIC_OFS) |=> ##1 $stable(ATOMIC_FIELDS))
      else $error("Atomic output moved on low byte.");
   chk_plain_out: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (WR_EN && ADDR == BLOCK_BASE + PLAIN_OFS + 8'h03) |=> ##1
      PLAIN_FIELDS[FIELD_W-1 -: BYTE_W] == $past(WDATA, 2))
      else $error("Plain top byte not placed at bits 31:24.");
   cov_atomic_commit: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      WR_EN && ADDR == BLOCK_BASE + ATOMIC_OFS + 8'h03);
   cov_plain_write: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      WR_EN && ADDR == BLOCK_BASE + PLAIN_OFS);
   cov_read_inst1: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      RD_EN && ADDR == BLOCK_BASE + INST_STRIDE);
   cov_stage_then_commit: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      (WR_EN && ADDR == BLOCK_BASE + INST_STRIDE + 8'h02) ##1
      (WR_EN && ADDR == BLOCK_BASE + INST_STRIDE + 8'h03));
   cov_unmapped_read: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      RD_EN && ADDR >= BLOCK_BASE + ADDR_W'(N_INST) * INST_STRIDE);

   chk_rvalid_pulse: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      !RD_EN
      |=> !RVALID)
      else $error("Read valid raised without a read.");
   chk_rdata_hold: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      !RD_EN
      |=> $stable(RDATA))
      else $error("Read data moved without a read.");
   chk_fields_reg: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      1'b1
      |=> ATOMIC_FIELDS == $past(atomic_live) && PLAIN_FIELDS == $past(plain_live))
      else $error("Field outputs do not follow the live values.");
   chk_reset_clear: assert property (@(posedge SYS_CLK)
      !RSTN
      |=> ATOMIC_FIELDS == '0 && PLAIN_FIELDS == '0 && !RVALID && RDATA == BYTE_ZERO)
      else $error("Outputs not cleared by reset.");
   chk_unmapped_ignore: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
      (WR_EN && (ADDR < BLOCK_BASE || ADDR >= BLOCK_BASE + ADDR_W'(N_INST) * INST_STRIDE))
      |=> $stable(atomic_live) && $stable(plain_live))
      else $error("Unmapped write changed a field.");

   // Each instance and each byte lane is checked at its own address.
   generate
      for (g = 0; g < N_INST; g++) begin : g_chk
         localparam logic [ADDR_W-1:0] INST_BASE = BLOCK_BASE + ADDR_W'(g) * INST_STRIDE;
         for (genvar l = 0; l < FIELD_BYTES; l++) begin : g_lane
            localparam logic [ADDR_W-1:0] LANE_OFS = ADDR_W'(l);
            chk_plain_lane: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
               (WR_EN && ADDR == INST_BASE + PLAIN_OFS + LANE_OFS)
               |=> plain_live[g*FIELD_W + l*BYTE_W +: BYTE_W] == $past(WDATA))
               else $error("Plain byte landed in the wrong lane.");
            chk_stage_lane: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
               (WR_EN && ADDR == INST_BASE + ATOMIC_OFS + LANE_OFS)
               |=> atomic_stage[g*FIELD_W + l*BYTE_W +: BYTE_W] == $past(WDATA))
               else $error("Atomic byte not staged in its lane.");
            chk_read_plain: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
               (RD_EN && ADDR == INST_BASE + PLAIN_OFS + LANE_OFS)
               |=> RDATA == $past(plain_live[g*FIELD_W + l*BYTE_W +: BYTE_W]))
               else $error("Plain read returned the wrong lane.");
            chk_read_stage: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
               (RD_EN && ADDR == INST_BASE + ATOMIC_OFS + LANE_OFS)
               |=> RDATA == $past(atomic_stage[g*FIELD_W + l*BYTE_W +: BYTE_W]))
               else $error("Atomic read returned the wrong lane.");
            if (l < FIELD_BYTES - 1) begin : g_low
               chk_atomic_wait: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
                  (WR_EN && ADDR == INST_BASE + ATOMIC_OFS + LANE_OFS)
                  |=> $stable(atomic_live[g*FIELD_W +: FIELD_W]))
                  else $error("Atomic field applied before its top byte.");
            end else begin : g_top
               chk_atomic_commit: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
                  (WR_EN && ADDR == INST_BASE + ATOMIC_OFS + LANE_OFS)
                  |=> atomic_live[g*FIELD_W +: FIELD_W] ==
                     {$past(WDATA), $past(atomic_stage[g*FIELD_W +: FIELD_W-BYTE_W])})
                  else $error("Atomic field not committed whole.");
            end
         end
      end
   endgenerate
endmodule

// ===== hdl/regbank_pkg.sv
package regbank_pkg;
   localparam int BYTE_W = 8;
   localparam int HWORD_W = 16;
   localparam int WORD_W = 32;
   localparam int DWORD_W = 64;
   localparam int ADDR_W = 8;
   localparam int FIELD_BYTES = 4;
   localparam int FIELD_W = FIELD_BYTES * BYTE_W;
   localparam int NUM_INST = 2;
   localparam logic [ADDR_W-1:0] BLOCK_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] INST_STRIDE = 8'h08;
   localparam logic [ADDR_W-1:0] ATOMIC_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] PLAIN_OFS = 8'h04;
   localparam logic [FIELD_W-1:0] FIELD_RST = 32'h0000_0000;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [BYTE_W-1:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic hit;
      logic atomic;
      logic [0:0] inst;
      logic [1:0] lane;
   } decode_t;
endpackage

// ===== hdl/field_slot.sv
`timescale 1ns/10ps
module field_slot
   import regbank_pkg::*;
#(
   parameter bit ATOMIC = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr,
   input wire logic [1:0] lane,
   input wire logic [BYTE_W-1:0] wdata,
   output logic [FIELD_W-1:0] stage,
   output logic [FIELD_W-1:0] live
);
   localparam logic [1:0] MSB_LANE = 2'(FIELD_BYTES - 1);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage <= FIELD_RST;
      end else if (wr) begin
         stage[lane*BYTE_W +: BYTE_W] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         live <= FIELD_RST;
      end else if (wr) begin
         if (!ATOMIC) begin
            live[lane*BYTE_W +: BYTE_W] <= wdata;
         end else if (lane == MSB_LANE) begin
            live <= {wdata, stage[FIELD_W-BYTE_W-1:0]};
         end
      end
   end

   chk_atomic_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (ATOMIC && wr && lane != MSB_LANE) |=> $stable(live))
      else $error("Atomic field changed before its top byte.");
   chk_plain_now: assert property (@(posedge clk) disable iff (!rst_n)
      (!ATOMIC && wr) |=> live[$past(lane)*BYTE_W +: BYTE_W] == $past(wdata))
      else $error("Plain byte not applied at once.");
   chk_atomic_whole: assert property (@(posedge clk) disable iff (!rst_n)
      (ATOMIC && wr && lane == MSB_LANE) |=> live == {$past(wdata), $past(stage[FIELD_W-BYTE_W-1:0])})
      else $error("Atomic field not applied whole.");
endmodule

// ===== tb/host_model.sv
`timescale 1ns/10ps
module host_model
   import regbank_pkg::*;
(
   input wire logic clk,
   output bus_req_t req
);
   initial req = '0;
   // Drives one request and waits one sampling edge; the request stays on the bus until the next put.
   task automatic put(input bus_req_t r);
      req <= r;
      @(posedge clk);
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb
   import regbank_pkg::*;
;
   localparam int STR = int'(INST_STRIDE);
   localparam int FW = NUM_INST * FIELD_W;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   bus_req_t req;
   logic [BYTE_W-1:0] rdata;
   logic rvalid;
   logic [FW-1:0] atom, plain, a_live, a_stg, p_live;
   logic [31:0] seed = 32'h0000_0760;
   int miscompares = 0;
   int n_tests = 0;
   always #4 clk = ~clk;
   host_model i_host (.clk(clk), .req(req));
   multibyte_register_update #(.N_INST(NUM_INST)) i_dut (.SYS_CLK(clk), .RSTN(rstn), .WR_EN(req.wr),
      .RD_EN(req.rd), .ADDR(req.addr), .WDATA(req.wdata), .RDATA(rdata), .RVALID(rvalid),
      .ATOMIC_FIELDS(atom), .PLAIN_FIELDS(plain));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int offs(input logic [ADDR_W-1:0] a);
      int o;
      o = int'(a) - int'(BLOCK_BASE);
      return (o < 0 || o >= NUM_INST * STR) ? -1 : o;
   endfunction
   function automatic void mdl(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
      int o;
      int f;
      o = offs(a);
      f = FIELD_W * (o / STR);
      if (o < 0) return;
      if (o % STR < int'(PLAIN_OFS)) begin
         a_stg[f + BYTE_W * (o % FIELD_BYTES) +: BYTE_W] = d;
         if (o % FIELD_BYTES == FIELD_BYTES - 1) a_live[f +: FIELD_W] = a_stg[f +: FIELD_W];
      end else begin
         p_live[f + BYTE_W * (o % FIELD_BYTES) +: BYTE_W] = d;
      end
   endfunction
   function automatic logic [BYTE_W-1:0] exp_rd(input logic [ADDR_W-1:0] a);
      int o;
      int k;
      o = offs(a);
      k = FIELD_W * (o / STR) + BYTE_W * (o % FIELD_BYTES);
      if (o < 0) return BYTE_ZERO;
      return (o % STR < int'(PLAIN_OFS)) ? a_stg[k +: BYTE_W] : p_live[k +: BYTE_W];
   endfunction
   task automatic chk(input logic [FW-1:0] seen, input logic [FW-1:0] want);
      n_tests++;
      if (seen !== want) begin
         miscompares++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
      i_host.put(bus_req_t'{1'b1, 1'b0, a, d});
      mdl(a, d);
   endtask
   task automatic settle();
      i_host.put('0);
      @(posedge clk);
      #1;
      chk(atom, a_live);
      chk(plain, p_live);
      chk(FW'(rvalid), FW'(1'b0));
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      i_host.put(bus_req_t'{1'b0, 1'b1, a, BYTE_ZERO});
      #1;
      chk(FW'(rvalid), FW'(1'b1));
      chk(FW'(rdata), FW'(exp_rd(a)));
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_sim();
   end
   initial begin
      a_live = '0;
      a_stg = '0;
      p_live = '0;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      settle();
      for (int l = 0; l < FIELD_BYTES; l++) begin
         wr(ADDR_W'(int'(BLOCK_BASE) + STR + l), BYTE_W'(8'hA0 + l));
      end
      settle();
      rd(8'hFF);
      repeat (80) begin
         seed = lfsr(seed);
         wr({3'b000, seed[4:0]}, seed[15:8]);
         settle();
         rd({3'b000, seed[4:0]});
      end
      end_sim();
   end
endmodule
